/* rtl/msd_decoder.sv */
`timescale 1ns/100ps
module msd_decoder
  import msd_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // straps and control
  input wire logic ext_access_pin,
  input wire logic security_bit,
  input wire logic can_reset_request_bit,
  input wire logic [1:0] bank_sel,
  input wire logic bank_sel_we,
  input wire logic [7:0] sp_val,
  // program fetch / code-table read
  input wire logic fetch_req,
  input wire logic code_table_read_instr,
  input wire logic [ADDR_W-1:0] code_addr,
  input wire logic [ADDR_W-1:0] cur_pc,
  output logic code_internal,
  output logic code_external,
  output logic code_blocked,
  // data access
  input wire logic data_req,
  input wire msd_acc_t data_kind,
  input wire logic data_wr,
  input wire logic [7:0] data_addr,
  input wire logic [2:0] pointer_sel,
  input wire logic [15:0] data_pointer_reg,
  output msd_tgt_t data_tgt,
  output logic [7:0] data_index,
  output logic [2:0] bit_pos,
  output logic [7:0] main_addr_of_pointer,
  // external bus
  input wire logic [7:0] low_port_in,
  input wire logic [7:0] wr_data,
  output logic [7:0] low_addr_data_port,
  output logic low_port_oe_n,
  output logic [7:0] high_addr_port,
  output logic wr_strobe_n,
  output logic rd_strobe_n,
  output logic ale,
  output logic [7:0] rd_data,
  // can pins
  input wire logic can_tx_a,
  input wire logic can_tx_b,
  input wire logic [1:0] p1_latch_hi,
  output logic can_tx_out_a,
  output logic can_tx_out_b,
  output logic can_tx_oe_a_n,
  output logic can_tx_oe_b_n,
  output logic [1:0] active_bank
);

  // ---------------------------------------------------------------
  // reset synchroniser
  // ---------------------------------------------------------------
  logic [1:0] rsync_q;
  logic rst_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsync_q <= 2'b00;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_n = rsync_q[1];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic strap_done;
    logic strap_hi;
    logic [1:0] bank;
    logic [2:0] ale_cnt;
    logic skip_pend;
    logic ale;
    logic wr_n;
    logic rd_n;
    logic low_oe_n;
    logic [7:0] low_port;
    logic [7:0] high_port;
    logic [7:0] rd_data;
    logic [1:0] p1;
  } msd_state_t;

  msd_state_t s_q, s_d;

  logic ext_data;
  logic rom_hit;
  logic from_ext;

  // ---------------------------------------------------------------
  // program space decode
  // ---------------------------------------------------------------
  always_comb begin
    // internal rom only when strap was high and address in low 16k
    rom_hit = s_q.strap_hi && (code_addr <= INT_ROM_LAST);
    from_ext = !(s_q.strap_hi && (cur_pc <= INT_ROM_LAST));
    code_blocked = code_table_read_instr && rom_hit
                   && (from_ext || security_bit);
    code_internal = (fetch_req || code_table_read_instr) && rom_hit
                    && !code_blocked;
    code_external = (fetch_req || code_table_read_instr) && !rom_hit;
  end

  // ---------------------------------------------------------------
  // data space decode
  // ---------------------------------------------------------------
  always_comb begin
    main_addr_of_pointer = {3'h0, s_q.bank, pointer_sel};
    data_tgt = TGT_NONE;
    data_index = 8'h00;
    bit_pos = 3'h0;
    ext_data = 1'b0;
    if (data_req) begin
      unique case (data_kind)
        ACC_DIRECT: begin
          data_index = data_addr;
          data_tgt = (data_addr >= DIRECT_SFR_BASE) ? TGT_SFR
                                                    : TGT_MAIN;
        end
        ACC_INDIRECT: begin
          data_index = data_addr;
          data_tgt = TGT_MAIN;
        end
        ACC_BIT: begin
          if (!data_addr[7]) begin
            data_index = BIT_AREA_BASE + {4'h0, data_addr[6:3]};
            data_tgt = TGT_MAIN;
          end else begin
            data_index = {data_addr[7:3], 3'h0};
            data_tgt = TGT_SFR;
          end
          bit_pos = data_addr[2:0];
        end
        ACC_STACK: begin
          data_index = sp_val;
          data_tgt = TGT_MAIN;
        end
        ACC_XDATA_PTR: begin
          data_index = data_addr;
          data_tgt = TGT_AUX;
        end
        ACC_XDATA_WIDE: begin
          data_index = data_pointer_reg[7:0];
          if (data_pointer_reg[15:8] == 8'h00) begin
            data_tgt = TGT_AUX;
          end else begin
            data_tgt = TGT_EXT;
            ext_data = 1'b1;
          end
        end
        default: begin
          data_tgt = TGT_NONE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      s_d.strap_hi = ext_access_pin;
    end
    if (bank_sel_we) begin
      s_d.bank = bank_sel;
    end
    // only external data moves drive ports and read/write strobes
    s_d.wr_n = 1'b1;
    s_d.rd_n = 1'b1;
    s_d.low_oe_n = 1'b1;
    if (ext_data) begin
      s_d.high_port = data_pointer_reg[15:8];
      s_d.wr_n = !data_wr;
      s_d.rd_n = data_wr;
      s_d.low_port = data_wr ? wr_data : data_pointer_reg[7:0];
      s_d.low_oe_n = !data_wr;
      s_d.skip_pend = 1'b1;
    end
    if (!s_q.rd_n) begin
      s_d.rd_data = low_port_in;
    end
    s_d.ale = 1'b0;
    if (s_q.ale_cnt == ALE_LAST) begin
      s_d.ale_cnt = 3'h0;
      if (s_q.skip_pend || ext_data) begin
        s_d.skip_pend = 1'b0;
      end else begin
        s_d.ale = 1'b1;
      end
    end else begin
      s_d.ale_cnt = s_q.ale_cnt + 3'h1;
    end
    s_d.p1 = p1_latch_hi;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.strap_done <= 1'b0;
      s_q.strap_hi <= 1'b0;
      s_q.bank <= BANK_RESET;
      s_q.ale_cnt <= 3'h0;
      s_q.skip_pend <= 1'b0;
      s_q.ale <= 1'b0;
      s_q.wr_n <= 1'b1;
      s_q.rd_n <= 1'b1;
      s_q.low_oe_n <= 1'b1;
      s_q.low_port <= PORT_RESET;
      s_q.high_port <= PORT_RESET;
      s_q.rd_data <= 8'h00;
      s_q.p1 <= 2'b11;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign active_bank = s_q.bank;
  assign low_addr_data_port = s_q.low_port;
  assign low_port_oe_n = s_q.low_oe_n;
  assign high_addr_port = s_q.high_port;
  assign wr_strobe_n = s_q.wr_n;
  assign rd_strobe_n = s_q.rd_n;
  assign ale = s_q.ale;
  assign rd_data = s_q.rd_data;

  // can pins: open drain port while can held in reset
  always_comb begin
    can_tx_out_a = 1'b0;
    can_tx_out_b = 1'b0;
    if (can_reset_request_bit) begin
      can_tx_oe_a_n = s_q.p1[0];
      can_tx_oe_b_n = s_q.p1[1];
    end else begin
      can_tx_out_a = can_tx_a;
      can_tx_out_b = can_tx_b;
      can_tx_oe_a_n = 1'b0;
      can_tx_oe_b_n = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  ext_fetch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_q.strap_done && !s_q.strap_hi && fetch_req) |-> code_external)
    else $error("fetch internal with strap low");
  rom_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    (code_internal |-> code_addr <= INT_ROM_LAST))
    else $error("internal fetch beyond rom");
  code_guard_a: assert property (@(posedge clk) disable iff (!rst_n)
    (code_table_read_instr && from_ext && rom_hit) |-> !code_internal)
    else $error("external code read internal rom");
  secure_rom_a: assert property (@(posedge clk) disable iff (!rst_n)
    (code_table_read_instr && security_bit) |-> !code_internal)
    else $error("secured rom was read");
  sfr_direct_a: assert property (@(posedge clk) disable iff (!rst_n)
    (data_req && data_kind == ACC_DIRECT && data_addr[7])
      |-> data_tgt == TGT_SFR)
    else $error("direct high address not sfr");
  aux_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    (data_req && data_tgt == TGT_AUX) |=> (wr_strobe_n && rd_strobe_n))
    else $error("aux access moved strobes");
  ptr_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (data_req && data_kind == ACC_XDATA_PTR) |-> data_tgt != TGT_EXT)
    else $error("pointer move reached external");
  ale_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
    ale |=> !ale [*5])
    else $error("address strobe too frequent");
  bank_reset_a: assert property (@(posedge clk)
    $rose(rst_n) |-> active_bank == 2'h0)
    else $error("bank not zero after reset");
  can_float_a: assert property (@(posedge clk) disable iff (!rst_n)
    (can_reset_request_bit && s_q.p1 == 2'b11)
      |-> (can_tx_oe_a_n && can_tx_oe_b_n))
    else $error("can pins driven in reset");

endmodule

/* rtl/msd_pkg.sv */
package msd_pkg;
  // program space split
  localparam logic [15:0] INT_ROM_LAST = 16'h3fff;
  localparam int INT_ROM_BYTES = 16384;
  localparam int PROG_SPACE_BYTES = 65536;
  // main ram layout
  localparam logic [7:0] BANK_STRIDE = 8'h08;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] BIT_AREA_LAST = 8'h2f;
  localparam logic [7:0] DIRECT_SFR_BASE = 8'h80;
  localparam logic [7:0] STACK_RESET = 8'h07;
  localparam logic [1:0] BANK_RESET = 2'h0;
  localparam logic [7:0] PORT_RESET = 8'hff;
  // address latch strobe period in clocks
  localparam int ALE_PERIOD = 6;
  localparam logic [2:0] ALE_LAST = 3'(ALE_PERIOD - 1);
  // data access kinds
  typedef enum logic [2:0] {
    ACC_DIRECT = 3'b000,
    ACC_INDIRECT = 3'b001,
    ACC_BIT = 3'b010,
    ACC_STACK = 3'b011,
    ACC_XDATA_PTR = 3'b100,
    ACC_XDATA_WIDE = 3'b101,
    ACC_NONE = 3'b110
  } msd_acc_t;
  // data target
  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_MAIN = 3'b001,
    TGT_SFR = 3'b010,
    TGT_AUX = 3'b011,
    TGT_EXT = 3'b100
  } msd_tgt_t;
endpackage

/* sim/msd_ext_mem.sv */
`timescale 1ns/100ps
module msd_ext_mem (
  // bus from the decoder
  input wire logic clk,
  input wire logic [7:0] high_addr_port,
  input wire logic [7:0] low_addr_data_port,
  input wire logic wr_strobe_n,
  input wire logic rd_strobe_n,
  // read data back
  output logic [7:0] low_port_in
);
  logic [7:0] mem [256];
  logic [7:0] last_q = 8'h00;
  always_ff @(posedge clk) begin
    if (!wr_strobe_n) begin
      mem[high_addr_port] <= low_addr_data_port;
    end
    if (!rd_strobe_n) begin
      last_q <= mem[high_addr_port];
    end
  end
  // a released bus shows the inverse of the last byte
  assign low_port_in = !rd_strobe_n ? mem[high_addr_port] : ~last_q;
endmodule

/* sim/tb_msd_decoder.sv */
`timescale 1ns/100ps
module tb_msd_decoder;
  import msd_pkg::*;
  logic clk = 0, arst_n = 0, ext_access_pin = 1, security_bit = 0;
  logic can_reset_request_bit = 1, bank_sel_we = 0, fetch_req = 0;
  logic code_table_read_instr = 0, data_req = 0, data_wr = 0;
  logic can_tx_a = 0, can_tx_b = 1;
  logic [1:0] bank_sel = 0, p1_latch_hi = 2'h3, active_bank;
  logic [7:0] sp_val = 0, data_addr = 0, wr_data = 0, low_port_in;
  logic [15:0] code_addr = 0, cur_pc = 0, data_pointer_reg = 0;
  logic [2:0] pointer_sel = 0, bit_pos;
  msd_acc_t data_kind = ACC_NONE;
  msd_tgt_t data_tgt;
  logic code_internal, code_external, code_blocked, low_port_oe_n;
  logic wr_strobe_n, rd_strobe_n, ale, can_tx_out_a, can_tx_out_b;
  logic can_tx_oe_a_n, can_tx_oe_b_n;
  logic [7:0] data_index, main_addr_of_pointer, low_addr_data_port;
  logic [7:0] high_addr_port, rd_data;
  int miscompares = 0, cmp_count = 0, ale_cnt = 0;

  msd_decoder msd_decoder_inst (.clk, .arst_n, .ext_access_pin,
    .security_bit, .can_reset_request_bit, .bank_sel, .bank_sel_we, .sp_val,
    .fetch_req, .code_table_read_instr, .code_addr, .cur_pc, .code_internal,
    .code_external, .code_blocked, .data_req, .data_kind, .data_wr,
    .data_addr, .pointer_sel, .data_pointer_reg, .data_tgt, .data_index,
    .bit_pos, .main_addr_of_pointer, .low_port_in, .wr_data,
    .low_addr_data_port, .low_port_oe_n, .high_addr_port, .wr_strobe_n,
    .rd_strobe_n, .ale, .rd_data, .can_tx_a, .can_tx_b, .p1_latch_hi,
    .can_tx_out_a, .can_tx_out_b, .can_tx_oe_a_n, .can_tx_oe_b_n,
    .active_bank);
  msd_ext_mem msd_ext_mem_inst (.clk, .high_addr_port, .low_addr_data_port,
    .wr_strobe_n, .rd_strobe_n, .low_port_in);

  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    ale_cnt += (ale === 1'b1);
  end

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic strap);
    @(posedge clk);
    arst_n <= 0;
    ext_access_pin <= strap;
    repeat (2) @(posedge clk);
    #1 chk({wr_strobe_n, rd_strobe_n, ale}, 3'b110);
    chk({low_addr_data_port, low_port_oe_n, active_bank}, 11'h7fc);
    @(posedge clk);
    arst_n <= 1;
    repeat (3) @(posedge clk);
  endtask

  task automatic fetch(input logic [15:0] a, input logic [1:0] e);
    @(posedge clk);
    code_addr <= a;
    #1 chk({code_internal, code_external}, e);
  endtask

  task automatic ctr(input logic [15:0] pc, input logic sec, input logic e);
    @(posedge clk);
    cur_pc <= pc;
    security_bit <= sec;
    code_addr <= 16'h0100;
    #1 chk(code_blocked, e);
  endtask

  task automatic dec(input msd_acc_t k, input logic [7:0] a,
                     input msd_tgt_t t, input logic [7:0] idx);
    @(posedge clk);
    data_kind <= k;
    data_addr <= a;
    #1 chk(data_tgt, t);
    chk(data_index, idx);
  endtask

  task automatic xacc(input logic wr, input logic [15:0] dp,
                      input logic [7:0] d);
    int n;
    @(posedge clk);
    data_req <= 1;
    data_kind <= ACC_XDATA_WIDE;
    data_wr <= wr;
    data_pointer_reg <= dp;
    wr_data <= d;
    @(posedge clk);
    data_req <= 0;
    #1;
    for (n = 0; n < 4 && (wr ? wr_strobe_n : rd_strobe_n) !== 0; n++) begin
      @(posedge clk);
      #1;
    end
    chk(n < 4, 1);
    chk(high_addr_port, dp[15:8]);
    chk(low_port_oe_n, !wr);
    if (wr) chk(low_addr_data_port, d);
    @(posedge clk);
    #1 if (!wr) chk(rd_data, d);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_code;
    do_reset(0);
    fetch_req <= 1;
    fetch(16'h0000, 2'b01);
    do_reset(1);
    fetch(16'h3fff, 2'b10);
    fetch(16'h4000, 2'b01);
    @(posedge clk);
    fetch_req <= 0;
    code_table_read_instr <= 1;
    ctr(16'h8000, 0, 1);
    ctr(16'h0200, 0, 0);
    ctr(16'h0200, 1, 1);
    @(posedge clk);
    code_table_read_instr <= 0;
    security_bit <= 0;
  endtask

  task automatic t_data;
    @(posedge clk);
    sp_val <= 8'hc0;
    data_req <= 1;
    dec(ACC_DIRECT, 8'h7f, TGT_MAIN, 8'h7f);
    dec(ACC_DIRECT, 8'h80, TGT_SFR, 8'h80);
    dec(ACC_INDIRECT, 8'h80, TGT_MAIN, 8'h80);
    dec(ACC_BIT, 8'h7f, TGT_MAIN, 8'h2f);
    chk(bit_pos, 3'h7);
    dec(ACC_STACK, 8'h00, TGT_MAIN, 8'hc0);
    dec(ACC_XDATA_PTR, 8'hff, TGT_AUX, 8'hff);
    dec(ACC_XDATA_WIDE, 8'h00, TGT_AUX, 8'h00);
    @(posedge clk);
    data_req <= 0;
    for (int b = 0; b < 4; b++) begin
      @(posedge clk);
      bank_sel <= b[1:0];
      bank_sel_we <= 1;
      pointer_sel <= 3'h1;
      @(posedge clk);
      bank_sel_we <= 0;
      @(posedge clk);
      #1 chk(active_bank, b[1:0]);
      chk(main_addr_of_pointer, 8'(b * 8 + 1));
    end
  endtask

  task automatic t_ext;
    logic [15:0] keep;
    xacc(1, 16'h1234, 8'ha5);
    xacc(1, 16'h5634, 8'h3c);
    xacc(0, 16'h1234, 8'ha5);
    xacc(0, 16'h5634, 8'h3c);
    keep = {high_addr_port, low_addr_data_port};
    @(posedge clk);
    data_req <= 1;
    data_kind <= ACC_XDATA_PTR;
    repeat (3) begin
      @(posedge clk);
      #1 chk({wr_strobe_n, rd_strobe_n}, 2'b11);
    end
    chk({high_addr_port, low_addr_data_port}, keep);
    @(posedge clk);
    data_req <= 0;
  endtask

  task automatic t_ale;
    @(posedge clk);
    #1 ale_cnt = 0;
    repeat (36) @(posedge clk);
    #1 chk(ale_cnt, 6);
    ale_cnt = 0;
    // the access itself spends three of the 36 counted edges
    xacc(0, 16'h1234, 8'ha5);
    repeat (33) @(posedge clk);
    #1 chk(ale_cnt, 5);
  endtask

  task automatic t_can;
    @(posedge clk);
    #1 chk({can_tx_oe_a_n, can_tx_oe_b_n}, 2'b11);
    @(posedge clk);
    can_reset_request_bit <= 0;
    #1 chk({can_tx_oe_a_n, can_tx_oe_b_n}, 2'b00);
    chk({can_tx_out_a, can_tx_out_b}, 2'b01);
  endtask

  initial begin
    #40000;
    miscompares++;
    end_of_test();
  end

  initial begin
    t_code();
    t_can();
    t_data();
    t_ext();
    t_ale();
    end_of_test();
  end
endmodule
